// >>> hdl/batt_seq_pkg.sv
// package: constants, types and register map of the battery cycle test sequencer
package batt_seq_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_DIS_CURR = 8'h04;
    localparam logic [7:0] OFS_DIS_VOLT = 8'h08;
    localparam logic [7:0] OFS_CHG_END_CURR = 8'h0c;
    localparam logic [7:0] OFS_CHG_TIME = 8'h10;
    localparam logic [7:0] OFS_DIS_TIME = 8'h14;
    localparam logic [7:0] OFS_CAP_LIMIT = 8'h18;
    localparam logic [7:0] OFS_TEST_TIME = 8'h1c;
    localparam logic [7:0] OFS_REST_TIME = 8'h20;
    localparam logic [7:0] OFS_CYCLES = 8'h24;
    localparam logic [7:0] OFS_CMD = 8'h28;
    localparam logic [7:0] OFS_STATUS = 8'h2c;
    localparam logic [7:0] OFS_ELAPSED = 8'h30;
    localparam logic [7:0] OFS_CYC_DONE = 8'h34;
    // ctrl fields
    localparam int CTRL_COMB_BIT = 0;
    localparam int CTRL_START_DIS_BIT = 1;
    localparam int CTRL_CAP_ACT_LSB = 2;
    localparam int CTRL_TIME_ACT_LSB = 4;
    // cmd fields
    localparam int CMD_RUN_BIT = 0;
    localparam int CMD_STOP_BIT = 1;
    // limits; times in seconds
    localparam logic [15:0] PHASE_MAX_S = 16'h8ca0; // 36000 s = 10 h
    localparam logic [15:0] REST_MIN_S = 16'h0001;
    localparam logic [15:0] REST_MAX_S = 16'h8ca0;
    localparam logic [15:0] TEST_MIN_S = 16'h0001;
    localparam logic [15:0] TEST_MAX_S = 16'h8ca0;
    localparam logic [23:0] CAP_MAX_CAH = 24'h98967f; // 99999.99 Ah in 0.01 Ah
    localparam logic [9:0] CYC_MAX = 10'h3e7; // 999
    // reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [15:0] REST_RST = 16'h0001;
    localparam logic [15:0] TIME_RST = 16'h8ca0;
    localparam logic [9:0] CYC_RST = 10'h001;

    typedef enum logic [1:0] {ACT_NONE, ACT_SIGNAL, ACT_END} limit_action_e;

    // condition codes as reported
    typedef enum logic [3:0] {
        COND_IDLE, COND_CHARGING, COND_DISCHARGING, COND_RESTING, COND_FINISHED,
        COND_ERROR, COND_SIG_AH, COND_SIG_TIME, COND_CAPACITY_ENDED_STATE, COND_END_TIME
    } cond_e;

    typedef struct packed {
        logic comb_mode;
        logic start_dis;
        limit_action_e cap_act;
        limit_action_e time_act;
    } seq_ctrl_s;

    typedef struct packed {
        logic [15:0] volt;
        logic [15:0] curr;
    } analog_s;
endpackage

// >>> hdl/sec_timer.sv
// one-second-tick timer with clear and limit compare
`timescale 1ns/1ps
module sec_timer import batt_seq_pkg::*; #(
    parameter int W = 16
) (
    input wire logic i_ref_clk, // clock
    input wire logic i_sys_rst, // sync reset
    input wire logic i_ce, // clock enable
    input wire logic i_clr, // clear count
    input wire logic i_tick, // one-second tick
    input wire logic i_run, // count when high
    input wire logic [W-1:0] i_limit, // limit in seconds
    output logic [W-1:0] o_count, // elapsed seconds
    output logic o_hit // count reached limit
);
    logic [W-1:0] count_reg;
    wire logic at_top = &count_reg;

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            count_reg <= '0;
        end else if (i_ce) begin
            if (i_clr) begin
                count_reg <= '0;
            end else if (i_run && i_tick && !at_top) begin
                count_reg <= count_reg + 1'b1;
            end
        end
    end

    assign o_count = count_reg;
    assign o_hit = (count_reg >= i_limit);
endmodule // sec_timer

// >>> hdl/batt_cycle_seq.sv
// battery combined charge/discharge test sequencer with ahb-lite registers
// Overview of operation
// - discharge, rest, start-phase and cycle settings act only in combined mode
// - discharging phase sinks programmed discharge current
// - discharging ends when battery voltage falls to discharge end voltage
// - each phase ends at its max duration, capped at ten hours
// - one shared capacity limit, 0 to 99999.99 Ah, checked against accumulation
// - global test time limit, 1 s to 10 h, checked across both phases
// - capacity limit action: ignore, signal and continue, or stop
// - independent test time action: ignore, signal and continue, or stop
// - rest between phases for programmed 1 to 36000 seconds
// - start-phase setting picks charging or discharging first
// - after any phase the opposite phase runs next
// - cycle count 1 to 999, zero repeats without limit
// - test ends only on cycle count or enabled stop criterion
// - host run command starts, stop command halts immediately
// - condition readable at any time
// - idle when never started or stopped; finished on normal completion
// - device alarm during test stops it and shows error
// - capacity limit shows signalled or ended state
// - test time limit shows signalled or ended state
// - running condition shows charging, discharging or resting
// - charging ends when charge current decays to end current
//
// Chosen here: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
module batt_cycle_seq import batt_seq_pkg::*; #(
    parameter int TW = 16,
    parameter int CW = 24
) (
    input wire logic i_ref_clk, // 20 mhz clock
    input wire logic i_sys_rst, // sync reset, active high
    input wire logic i_ce, // clock enable, freezes state when low
    input wire logic i_hsel, // ahb select
    input wire logic [31:0] i_haddr, // ahb address
    input wire logic [1:0] i_htrans, // ahb transfer type
    input wire logic i_hwrite, // ahb write
    input wire logic [2:0] i_hsize, // ahb size
    input wire logic [31:0] i_hwdata, // ahb write data
    input wire logic i_hready, // ahb bus ready
    output logic [31:0] o_hrdata, // ahb read data
    output logic o_hreadyout, // ahb slave ready
    output logic o_hresp, // ahb response, always okay
    input wire logic i_sec_tick, // one-second tick pulse
    input wire analog_s i_meas, // measured battery voltage and current
    input wire logic [CW-1:0] i_acc_cap, // accumulated capacity, 0.01 ah
    input wire logic i_alarm, // device alarm level
    output logic o_charge_en, // charging phase active
    output logic o_discharge_en, // discharging phase active
    output logic [15:0] o_dis_curr_set, // discharge current setpoint
    output logic o_limit_signal, // a limit reached, test continues
    output logic o_running // test running
);
    typedef enum logic [2:0] {S_IDLE, S_CHG, S_DIS, S_REST_C, S_REST_D} seq_e;

    // bus registers
    seq_ctrl_s ctrl_reg;
    logic [15:0] dis_curr_reg, dis_volt_reg, chg_end_curr_reg;
    logic [TW-1:0] chg_time_reg, dis_time_reg, test_time_reg, rest_time_reg;
    logic [CW-1:0] cap_lim_reg;
    logic [9:0] cycles_reg;
    // sequencer state
    seq_e st_reg, st_next;
    cond_e cond_reg, cond_next;
    logic [9:0] cyc_done_reg;
    logic half_reg; // one phase of the current pair done
    logic cap_sig_reg, time_sig_reg;
    // ahb data phase
    logic wr_pend_reg, rd_pend_reg;
    logic [7:0] addr_reg;
    logic [31:0] rdata_reg;

    function automatic logic [TW-1:0] clamp_t(input logic [31:0] v, input logic [15:0] lo, input logic [15:0] hi);
        logic [TW-1:0] r;
        r = v[TW-1:0];
        if (v < {16'h0000, lo}) begin
            r = lo[TW-1:0];
        end else if (v > {16'h0000, hi}) begin
            r = hi[TW-1:0];
        end
        return r;
    endfunction

    // saturate against the whole written word, so large values cannot wrap to small ones
    function automatic logic [31:0] sat_load(input logic [31:0] v, input logic [31:0] hi);
        return (v > hi) ? hi : v;
    endfunction

    // the active phase has met its own end condition
    function automatic logic phase_over(input seq_e s, input logic c_end, input logic d_end);
        return ((s == S_CHG) && c_end) || ((s == S_DIS) && d_end);
    endfunction

    // address phase decode
    wire logic addr_ok = i_hsel && i_hready && i_htrans[1];
    wire logic do_wr = wr_pend_reg;
    wire logic wr_cmd = do_wr && (addr_reg == OFS_CMD);
    wire logic cmd_run = wr_cmd && i_hwdata[CMD_RUN_BIT];
    wire logic cmd_stop = wr_cmd && i_hwdata[CMD_STOP_BIT];
    // a refused run leaves timers and counters untouched
    wire logic run_ok = cmd_run && ctrl_reg.comb_mode && !i_alarm;
    wire logic busy = (st_reg != S_IDLE);
    wire logic in_rest = (st_reg == S_REST_C) || (st_reg == S_REST_D);

    // timers: one shared by both phases and the rests, and one over the whole test
    // clears on state changes only, so a run written mid-test cannot stretch a phase
    // one timer serves phases and rests, since they never overlap
    wire logic phase_clr = (st_reg != st_next);
    wire logic [TW-1:0] phase_limit = (st_reg == S_CHG) ? chg_time_reg :
                                      (st_reg == S_DIS) ? dis_time_reg : rest_time_reg;
    logic phase_hit, test_hit;
    logic [TW-1:0] phase_cnt, test_cnt;

    sec_timer #(.W(TW)) u_phase_timer (
        .i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst),
        .i_ce(i_ce),
        .i_clr(phase_clr),
        .i_tick(i_sec_tick),
        .i_run(busy),
        .i_limit(phase_limit),
        .o_count(phase_cnt),
        .o_hit(phase_hit)
    );

    sec_timer #(.W(TW)) u_test_timer (
        .i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst),
        .i_ce(i_ce),
        .i_clr(run_ok && !busy),
        .i_tick(i_sec_tick),
        .i_run(busy),
        .i_limit(test_time_reg),
        .o_count(test_cnt),
        .o_hit(test_hit)
    );

    // measured levels are compared raw; any filtering happens ahead of this block
    // phase end conditions
    wire logic chg_end = phase_hit || (i_meas.curr <= chg_end_curr_reg);
    wire logic dis_end = phase_hit || (i_meas.volt <= dis_volt_reg);
    // limits are level compares, so a held limit keeps its condition shown
    wire logic cap_hit = (i_acc_cap >= cap_lim_reg);
    wire logic cap_stop = cap_hit && (ctrl_reg.cap_act == ACT_END);
    wire logic cap_sig = cap_hit && (ctrl_reg.cap_act == ACT_SIGNAL);
    wire logic time_stop = test_hit && (ctrl_reg.time_act == ACT_END);
    wire logic time_sig = test_hit && (ctrl_reg.time_act == ACT_SIGNAL);
    // a pair completes when the second phase of it ends
    wire logic phase_end = phase_over(st_reg, chg_end, dis_end);
    wire logic pair_done = half_reg && phase_end;
    wire logic [9:0] cyc_inc = cyc_done_reg + 10'h001;
    wire logic cycles_met = pair_done && (cycles_reg != 10'h000) && (cyc_inc >= cycles_reg);
    // the reported phase is the one entered at this edge
    wire cond_e run_cond = (st_next == S_CHG) ? COND_CHARGING :
                           (st_next == S_DIS) ? COND_DISCHARGING : COND_RESTING;
    wire logic test_start = !busy && (st_next != S_IDLE);

    always_comb begin
        st_next = st_reg;
        cond_next = cond_reg;
        case (st_reg)
            S_IDLE: begin
                if (run_ok) begin
                    st_next = ctrl_reg.start_dis ? S_DIS : S_CHG;
                end
            end
            S_CHG: begin
                if (chg_end) begin
                    st_next = S_REST_D;
                end
            end
            S_DIS: begin
                if (dis_end) begin
                    st_next = S_REST_C;
                end
            end
            S_REST_C: begin
                if (phase_hit) begin
                    st_next = S_CHG;
                end
            end
            S_REST_D: begin
                if (phase_hit) begin
                    st_next = S_DIS;
                end
            end
            default: begin
                st_next = S_IDLE;
            end
        endcase
        if (busy) begin
            // stop criteria in priority: manual stop, alarm, limits, cycles
            if (cmd_stop) begin
                st_next = S_IDLE;
                cond_next = COND_IDLE;
            end else if (i_alarm) begin
                st_next = S_IDLE;
                cond_next = COND_ERROR;
            end else if (cap_stop) begin
                st_next = S_IDLE;
                cond_next = COND_CAPACITY_ENDED_STATE;
            end else if (time_stop) begin
                st_next = S_IDLE;
                cond_next = COND_END_TIME;
            end else if (cycles_met) begin
                st_next = S_IDLE;
                cond_next = COND_FINISHED;
            end else if (cap_sig) begin
                cond_next = COND_SIG_AH;
            end else if (time_sig) begin
                cond_next = COND_SIG_TIME;
            end else begin
                cond_next = run_cond;
            end
        end else if (st_next != S_IDLE) begin
            cond_next = run_cond;
        end
    end

    // sequencer registers
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            st_reg <= S_IDLE;
            cond_reg <= COND_IDLE;
            cyc_done_reg <= '0;
            half_reg <= 1'b0;
            cap_sig_reg <= 1'b0;
            time_sig_reg <= 1'b0;
        end else if (i_ce) begin
            st_reg <= st_next;
            cond_reg <= cond_next;
            // limit flags are registered so the signal output cannot glitch
            cap_sig_reg <= busy && cap_sig;
            time_sig_reg <= busy && time_sig;
            if (test_start) begin
                cyc_done_reg <= '0;
                half_reg <= 1'b0;
            end else if (phase_end) begin
                half_reg <= !half_reg;
                // the count sticks at its top when cycles repeat without limit
                if (pair_done && cyc_done_reg != CYC_MAX) begin
                    cyc_done_reg <= cyc_inc;
                end
            end
        end
    end

    // ahb-lite slave: zero wait states, writes land in the data phase
    // hsize is not decoded: every register is one whole word
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_reg <= '0;
        end else if (i_ce) begin
            wr_pend_reg <= addr_ok && i_hwrite;
            rd_pend_reg <= addr_ok && !i_hwrite;
            if (addr_ok) begin
                addr_reg <= i_haddr[7:0];
            end
        end
    end

    // config writes; settings clamp into their documented ranges
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            ctrl_reg <= seq_ctrl_s'(CTRL_RST[5:0]);
            dis_curr_reg <= '0;
            dis_volt_reg <= '0;
            chg_end_curr_reg <= '0;
            chg_time_reg <= TIME_RST;
            dis_time_reg <= TIME_RST;
            test_time_reg <= TIME_RST;
            rest_time_reg <= REST_RST;
            cap_lim_reg <= CAP_MAX_CAH;
            cycles_reg <= CYC_RST;
        end else if (i_ce && do_wr) begin
            case (addr_reg)
                OFS_CTRL: begin
                    ctrl_reg.comb_mode <= i_hwdata[CTRL_COMB_BIT];
                    ctrl_reg.start_dis <= i_hwdata[CTRL_START_DIS_BIT];
                    ctrl_reg.cap_act <= limit_action_e'(i_hwdata[CTRL_CAP_ACT_LSB +: 2]);
                    ctrl_reg.time_act <= limit_action_e'(i_hwdata[CTRL_TIME_ACT_LSB +: 2]);
                end
                OFS_DIS_CURR: dis_curr_reg <= i_hwdata[15:0];
                OFS_DIS_VOLT: dis_volt_reg <= i_hwdata[15:0];
                OFS_CHG_END_CURR: chg_end_curr_reg <= i_hwdata[15:0];
                OFS_CHG_TIME: chg_time_reg <= clamp_t(i_hwdata, REST_MIN_S, PHASE_MAX_S);
                OFS_DIS_TIME: dis_time_reg <= clamp_t(i_hwdata, REST_MIN_S, PHASE_MAX_S);
                OFS_TEST_TIME: test_time_reg <= clamp_t(i_hwdata, TEST_MIN_S, TEST_MAX_S);
                OFS_REST_TIME: rest_time_reg <= clamp_t(i_hwdata, REST_MIN_S, REST_MAX_S);
                // a wide write saturates at the top instead of wrapping
                OFS_CAP_LIMIT: cap_lim_reg <= CW'(sat_load(i_hwdata, 32'(CAP_MAX_CAH)));
                OFS_CYCLES: cycles_reg <= 10'(sat_load(i_hwdata, 32'(CYC_MAX)));
                default: begin
                end
            endcase
        end
    end

    // read mux, readable any time
    // unmapped offsets and the write-only command word read as zero
    logic [31:0] rd_mux;
    always_comb begin
        case (i_haddr[7:0])
            OFS_CTRL: rd_mux = {26'h0, ctrl_reg.time_act, ctrl_reg.cap_act, ctrl_reg.start_dis, ctrl_reg.comb_mode};
            OFS_DIS_CURR: rd_mux = {16'h0, dis_curr_reg};
            OFS_DIS_VOLT: rd_mux = {16'h0, dis_volt_reg};
            OFS_CHG_END_CURR: rd_mux = {16'h0, chg_end_curr_reg};
            OFS_CHG_TIME: rd_mux = {16'h0, chg_time_reg};
            OFS_DIS_TIME: rd_mux = {16'h0, dis_time_reg};
            OFS_CAP_LIMIT: rd_mux = {8'h0, cap_lim_reg};
            OFS_TEST_TIME: rd_mux = {16'h0, test_time_reg};
            OFS_REST_TIME: rd_mux = {16'h0, rest_time_reg};
            OFS_CYCLES: rd_mux = {22'h0, cycles_reg};
            OFS_STATUS: rd_mux = {20'h0, 3'h0, busy, 4'h0, cond_reg};
            OFS_ELAPSED: rd_mux = {phase_cnt, test_cnt};
            OFS_CYC_DONE: rd_mux = {22'h0, cyc_done_reg};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // read data captured at address phase so it stands through the data phase
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            rdata_reg <= '0;
        end else if (i_ce && addr_ok && !i_hwrite) begin
            rdata_reg <= rd_mux;
        end
    end

    // no wait states: every access completes in its data phase
    assign o_hrdata = rdata_reg;
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;
    assign o_charge_en = (st_reg == S_CHG);
    assign o_discharge_en = (st_reg == S_DIS);
    assign o_dis_curr_set = (st_reg == S_DIS) ? dis_curr_reg : 16'h0000;
    assign o_limit_signal = cap_sig_reg || time_sig_reg;
    assign o_running = busy || in_rest;
endmodule // batt_cycle_seq

// >>> verif/batt_cycle_seq_assertions.sv
// concurrent checks on the sequencer's top-level ports
`timescale 1ns/1ps
module batt_cycle_seq_assertions import batt_seq_pkg::*; (
    input wire logic i_ref_clk, // clock
    input wire logic i_sys_rst, // sync reset
    input wire logic i_ce, // clock enable
    input wire logic i_alarm, // device alarm
    input wire logic o_hreadyout, // slave ready
    input wire logic o_hresp, // slave response
    input wire logic o_charge_en, // charging phase
    input wire logic o_discharge_en, // discharging phase
    input wire logic [15:0] o_dis_curr_set, // discharge setpoint
    input wire logic o_running // test running
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);

    a_bus_zero_wait: assert property (o_hreadyout && !o_hresp)
        else $error("bus slave stalled or answered with error");
    a_phase_exclusive: assert property (!(o_charge_en && o_discharge_en))
        else $error("both phases active");
    a_setpoint_only_dis: assert property (!o_discharge_en |-> o_dis_curr_set == 16'h0000)
        else $error("discharge setpoint outside discharging phase");
    a_phase_means_run: assert property ((o_charge_en || o_discharge_en) |-> o_running)
        else $error("phase active while not running");
    a_alarm_halts: assert property ((o_running && i_alarm && i_ce) |=> !o_running)
        else $error("alarm did not stop the test");
    a_start_in_phase: assert property ($rose(o_running) |-> (o_charge_en || o_discharge_en))
        else $error("test started outside a phase");
    a_rest_after_chg: assert property (($fell(o_charge_en) && o_running) |-> !o_discharge_en)
        else $error("no rest after charging");
    a_rest_after_dis: assert property (($fell(o_discharge_en) && o_running) |-> !o_charge_en)
        else $error("no rest after discharging");
    a_freeze_on_ce: assert property (!i_ce |=> $stable(o_running) && $stable(o_charge_en))
        else $error("state moved while clock enable low");
endmodule // batt_cycle_seq_assertions

// >>> verif/ahb_host.sv
// remote host model: single-word ahb-lite reads and writes
`timescale 1ns/1ps
module ahb_host (
    input wire logic i_clk, // bus clock
    input wire logic i_hready, // bus ready
    input wire logic [31:0] i_hrdata, // read data
    output logic o_hsel, // select
    output logic [31:0] o_haddr, // address
    output logic [1:0] o_htrans, // transfer type
    output logic o_hwrite, // write
    output logic [2:0] o_hsize, // always a word
    output logic [31:0] o_hwdata // write data
);
    initial begin
        o_hsel = 1'b0;
        o_haddr = 32'h0000_0000;
        o_htrans = 2'b00;
        o_hwrite = 1'b0;
        o_hsize = 3'b010;
        o_hwdata = 32'h5a5a_a5a5;
    end

    // call right after a rising edge; returns at the edge that ends the data phase
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        o_hsel <= 1'b1;
        o_haddr <= {24'h000000, a};
        o_htrans <= 2'b10;
        o_hwrite <= wr;
        @(posedge i_clk);
        while (!i_hready) @(posedge i_clk);
        o_hsel <= 1'b0;
        o_htrans <= 2'b00;
        o_hwdata <= wr ? d : ~o_hwdata;
        @(posedge i_clk);
        while (!i_hready) @(posedge i_clk);
        q = i_hrdata;
        // released data must not look valid
        o_hwdata <= ~d;
    endtask
endmodule // ahb_host

// >>> verif/batt_cycle_seq_test.sv
// self-checking bench for the battery cycle test sequencer
`timescale 1ns/1ps
module batt_cycle_seq_test import batt_seq_pkg::*;;
    logic i_ref_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_ce = 1'b1;
    logic i_sec_tick = 1'b0;
    logic i_alarm = 1'b0;
    analog_s i_meas = 32'hffff_ffff;
    logic [23:0] i_acc_cap = 24'hffffff;
    wire hsel, hwrite, hready, hresp, charge_en, discharge_en, limit_signal, running;
    wire [31:0] haddr, hwdata, hrdata;
    wire [1:0] htrans;
    wire [2:0] hsize;
    wire [15:0] dis_curr_set;
    int err_total = 0;
    int n_checks = 0;
    logic [31:0] q, dc, dv;
    logic [23:0] cl;
    limit_action_e act;

    batt_cycle_seq batt_cycle_seq_inst (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce),
        .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
        .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
        .i_sec_tick(i_sec_tick), .i_meas(i_meas), .i_acc_cap(i_acc_cap), .i_alarm(i_alarm),
        .o_charge_en(charge_en), .o_discharge_en(discharge_en), .o_dis_curr_set(dis_curr_set),
        .o_limit_signal(limit_signal), .o_running(running));
    ahb_host ahb_host_inst (.i_clk(i_ref_clk), .i_hready(hready), .i_hrdata(hrdata), .o_hsel(hsel),
        .o_haddr(haddr), .o_htrans(htrans), .o_hwrite(hwrite), .o_hsize(hsize), .o_hwdata(hwdata));

    initial begin
        forever #25 i_ref_clk = ~i_ref_clk;
    end

    task automatic tally_and_finish;
        if (err_total == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] unused;
        ahb_host_inst.xfer(1'b1, a, d, unused);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        ahb_host_inst.xfer(1'b0, a, 32'h0000_0000, d);
    endtask

    // polls the condition a bounded number of times before comparing
    task automatic cond_is(input cond_e e);
        logic [31:0] s = 32'hffff_ffff;
        for (int n = 0; n < 8 && s[3:0] !== e; n++) rd(OFS_STATUS, s);
        chk({28'h0, s[3:0]}, {28'h0, e});
    endtask

    task automatic tick;
        i_sec_tick <= 1'b1;
        @(posedge i_ref_clk);
        i_sec_tick <= 1'b0;
        @(posedge i_ref_clk);
    endtask

    task automatic start(input logic [31:0] c);
        wr(OFS_CTRL, c);
        wr(OFS_CMD, 32'h1);
    endtask

    function automatic logic [31:0] ctrl_w(input logic sd, input limit_action_e ca, input limit_action_e ta);
        return {26'h0, ta, ca, sd, 1'b1};
    endfunction

    function automatic cond_e lim_cond(input logic is_time, input limit_action_e a);
        if (a == ACT_SIGNAL) return is_time ? COND_SIG_TIME : COND_SIG_AH;
        return is_time ? COND_END_TIME : COND_CAPACITY_ENDED_STATE;
    endfunction

    initial begin
        void'($urandom(65596));
        repeat (16) @(posedge i_ref_clk);
        i_sys_rst <= 1'b0;
        @(posedge i_ref_clk);
        cond_is(COND_IDLE);
        rd(OFS_REST_TIME, q);
        chk(q, {16'h0, REST_RST});
        rd(OFS_CYCLES, q);
        chk(q, {22'h0, CYC_RST});
        wr(8'h3c, 32'hffff_ffff);
        rd(8'h3c, q);
        chk(q, 32'h0);
        start(32'h0);
        cond_is(COND_IDLE);
        chk(running, 1'b0);
        dc = {16'h0, 16'($urandom)};
        dv = {16'h0, 16'($urandom_range(1, 32767))};
        wr(OFS_DIS_CURR, dc);
        wr(OFS_DIS_VOLT, dv);
        wr(OFS_CHG_END_CURR, 32'h10);
        start(ctrl_w(1'b0, ACT_NONE, ACT_NONE));
        cond_is(COND_CHARGING);
        i_meas.curr <= 16'h0010;
        cond_is(COND_RESTING);
        i_meas.curr <= 16'hffff;
        tick();
        cond_is(COND_DISCHARGING);
        chk({16'h0, dis_curr_set}, dc);
        chk(discharge_en, 1'b1);
        i_meas.volt <= dv[15:0];
        cond_is(COND_FINISHED);
        rd(OFS_CYC_DONE, q);
        chk(q, 32'h1);
        i_meas.volt <= 16'hffff;
        wr(OFS_DIS_TIME, 32'h2);
        start(ctrl_w(1'b1, ACT_NONE, ACT_NONE));
        cond_is(COND_DISCHARGING);
        tick();
        cond_is(COND_DISCHARGING);
        tick();
        cond_is(COND_RESTING);
        tick();
        cond_is(COND_CHARGING);
        rd(OFS_ELAPSED, q);
        chk(q, 32'h0000_0003);
        // clock enable low must hold the phase even with its end condition present
        i_ce <= 1'b0;
        i_meas.curr <= 16'h0000;
        repeat (3) @(posedge i_ref_clk);
        chk(charge_en, 1'b1);
        i_meas.curr <= 16'hffff;
        i_ce <= 1'b1;
        @(posedge i_ref_clk);
        wr(OFS_CMD, 32'h2);
        cond_is(COND_IDLE);
        start(ctrl_w(1'b0, ACT_NONE, ACT_NONE));
        rd(OFS_ELAPSED, q);
        chk(q, 32'h0);
        wr(OFS_CMD, 32'h2);
        wr(OFS_CYCLES, 32'h0000_0400);
        rd(OFS_CYCLES, q);
        chk(q, {22'h0, CYC_MAX});
        // zero cycles: a completed pair must lead to a rest, not to the end
        wr(OFS_CYCLES, 32'h0);
        start(ctrl_w(1'b0, ACT_NONE, ACT_NONE));
        i_meas <= {dv[15:0], 16'h0000};
        cond_is(COND_RESTING);
        tick();
        cond_is(COND_RESTING);
        rd(OFS_CYC_DONE, q);
        chk(q, 32'h1);
        wr(OFS_CMD, 32'h2);
        i_meas <= 32'hffff_ffff;
        for (int k = 0; k < 4; k++) begin
            act = k[0] ? ACT_END : ACT_SIGNAL;
            cl = 24'($urandom_range(1, 9999999));
            wr(OFS_CAP_LIMIT, {8'h00, cl});
            wr(OFS_TEST_TIME, 32'h2);
            i_acc_cap <= cl - 24'h1;
            start(k[1] ? ctrl_w(1'b0, ACT_NONE, act) : ctrl_w(1'b0, act, ACT_NONE));
            cond_is(COND_CHARGING);
            tick();
            chk(limit_signal, 1'b0);
            if (k[1]) tick(); else i_acc_cap <= cl;
            cond_is(lim_cond(k[1], act));
            chk(running, act == ACT_SIGNAL);
            chk(limit_signal, act == ACT_SIGNAL);
            wr(OFS_CMD, 32'h2);
            i_acc_cap <= 24'hffffff;
        end
        wr(OFS_TEST_TIME, 32'h8ca0);
        start(ctrl_w(1'b0, ACT_NONE, ACT_NONE));
        cond_is(COND_CHARGING);
        i_alarm <= 1'b1;
        cond_is(COND_ERROR);
        chk(running, 1'b0);
        i_alarm <= 1'b0;
        tally_and_finish();
    end

    initial begin
        repeat (20000) @(posedge i_ref_clk);
        err_total++;
        tally_and_finish();
    end
endmodule // batt_cycle_seq_test

bind batt_cycle_seq batt_cycle_seq_assertions batt_cycle_seq_assertions_inst (.i_ref_clk, .i_sys_rst, .i_ce,
    .i_alarm, .o_hreadyout, .o_hresp, .o_charge_en, .o_discharge_en, .o_dis_curr_set, .o_running);
